// File: pkg/rtsc_pkg.sv
// package of constants and types for the reset and test strap control block
`default_nettype none

package rtsc_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned STRAP_W = 8;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned SAMPLE_DELAY_NS = 1500;
  localparam int unsigned SAMPLE_DELAY_PS = SAMPLE_DELAY_NS * 1000;
  // approximate figure, round down to whole cycles
  localparam int unsigned SAMPLE_DELAY_CYC = SAMPLE_DELAY_PS / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;
  localparam logic [STRAP_W-1:0] TEST_OUT_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

  // ****************************************************************
  // sequencer states, gray along the path
  // ****************************************************************
  typedef enum logic [1:0]
  {
    RTSC_HOLD = 2'b00,
    RTSC_WAIT = 2'b01,
    RTSC_SAMPLE = 2'b11,
    RTSC_RUN = 2'b10
  } rtsc_state_t;

endpackage : rtsc_pkg

`default_nettype wire

// File: design/rtsc_sync.sv
// two flip-flop synchroniser, one per bit
`default_nettype none

module rtsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } rtsc_sync_st_t;

  rtsc_sync_st_t s_reg;
  rtsc_sync_st_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.meta = i_async;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_sync = s_reg.sync;

endmodule // rtsc_sync

`default_nettype wire

// File: design/rtsc_top.sv
// power-on reset sequencing and test strap capture
//
// Contract
// - start self-configuration on a rising edge of power-on reset low
// - no output active while power-on reset low is held low except the pull-down enables; o_test_mode and o_test_mode_sel keep the last capture
// - all eight test pins undriven while reset is held low
// - about 1.5 us after release, capture pins as mode, then drive them
// - weak pull-down on each test pin so open pins read low
// - any captured high selects test mode; all low selects normal
// - normal mode: pins are test outputs only; outside leaves them undriven
`default_nettype none

module rtsc_top
  import rtsc_pkg::*;
#(
  parameter int unsigned DELAY_CYC = rtsc_pkg::SAMPLE_DELAY_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // pins from the power manager and test port
  input wire logic i_power_on_reset_low,
  input wire logic i_test_port_reset_low,
  // test strap pins
  input wire logic [rtsc_pkg::STRAP_W-1:0] i_test_strap_pin,
  output logic [rtsc_pkg::STRAP_W-1:0] o_test_strap_pin,
  output logic [rtsc_pkg::STRAP_W-1:0] o_test_strap_oe,
  output logic [rtsc_pkg::STRAP_W-1:0] o_test_strap_pulldown,
  // internal test output data
  input wire logic [rtsc_pkg::STRAP_W-1:0] i_test_out_data,
  // status
  output logic [rtsc_pkg::STRAP_W-1:0] o_test_mode_sel,
  output logic o_test_mode,
  output logic o_config_start,
  output logic o_ready,
  output logic o_test_port_fault
);
  import rtsc_pkg::*;

  // ****************************************************************
  // derived constants
  // ****************************************************************
  // the counter runs from 0 to DELAY_LAST in the wait state, so the wait
  // lasts DELAY_CYC cycles; a DELAY_CYC above 2**CNT_W would wrap the
  // counter and cut the wait short
  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYC - 1);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [STRAP_W+1:0] sync_in;
  logic [STRAP_W+1:0] sync_out;
  logic por_n_s;
  logic tport_n_s;
  logic [STRAP_W-1:0] strap_s;

  // one synchroniser for all pins; the straps are read long after the
  // pins settle, so bits that land a cycle apart do no harm
  // no gray code needed for that reason
  assign sync_in = {i_power_on_reset_low, i_test_port_reset_low, i_test_strap_pin};

  rtsc_sync #(
    .WIDTH(STRAP_W + 2)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign por_n_s = sync_out[STRAP_W+1];
  assign tport_n_s = sync_out[STRAP_W];
  assign strap_s = sync_out[STRAP_W-1:0];

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed
  {
    // sequencer
    rtsc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic por_d;
    // captured straps
    logic [STRAP_W-1:0] mode_sel;
    logic test_mode;
    // pin drive
    logic [STRAP_W-1:0] pin_out;
    logic [STRAP_W-1:0] pin_oe;
    logic [STRAP_W-1:0] pull_en;
    // status
    logic start;
    logic ready;
    logic tport_fault;
  } rtsc_st_t;

  rtsc_st_t st_reg;
  rtsc_st_t st_next;

  // ****************************************************************
  // release detect
  // ****************************************************************
  logic por_rise;

  // por_d clears on reset, so a pin already high at reset release counts as a rise
  // a rise during wait or run cannot occur: a fall first forces hold
  assign por_rise = por_n_s & ~st_reg.por_d;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.por_d = por_n_s;
    st_next.start = 1'b0;
    st_next.pull_en = '1;
    // hazard flagged only once running; start-up can fail if high
    st_next.tport_fault = st_reg.ready & tport_n_s;
    case (st_reg.state)
      RTSC_HOLD:
      begin
        // nothing drives the pins until the run state, after the capture
        st_next.cnt = CNT_RST;
        st_next.pin_oe = '0;
        st_next.pin_out = TEST_OUT_RST;
        st_next.ready = 1'b0;
        if (por_rise)
        begin
          st_next.state = RTSC_WAIT;
          st_next.start = 1'b1;
        end
      end
      RTSC_WAIT:
      begin
        // straps need time to settle through the pull-downs
        st_next.cnt = st_reg.cnt + CNT_W'(1);
        if (st_reg.cnt == DELAY_LAST)
        begin
          st_next.state = RTSC_SAMPLE;
        end
      end
      RTSC_SAMPLE:
      begin
        // open pins read low through the pull-down
        st_next.mode_sel = strap_s;
        st_next.test_mode = |strap_s;
        st_next.state = RTSC_RUN;
      end
      RTSC_RUN:
      begin
        // data presented now leaves the pins one cycle later
        st_next.pin_oe = '1;
        st_next.pin_out = i_test_out_data;
        st_next.ready = 1'b1;
      end
      default:
      begin
        st_next.state = RTSC_HOLD;
      end
    endcase
    // reset low overrides every state
    // mode_sel and test_mode keep the last capture through reset low
    if (!por_n_s)
    begin
      st_next.state = RTSC_HOLD;
      st_next.pin_oe = '0;
      st_next.pin_out = TEST_OUT_RST;
      st_next.ready = 1'b0;
      st_next.start = 1'b0;
      st_next.tport_fault = 1'b0;
      st_next.cnt = CNT_RST;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= '{
        state: RTSC_HOLD,
        cnt: CNT_RST,
        por_d: 1'b0,
        mode_sel: STRAP_RST,
        test_mode: 1'b0,
        pin_out: TEST_OUT_RST,
        pin_oe: '0,
        pull_en: '1,
        start: 1'b0,
        ready: 1'b0,
        tport_fault: 1'b0
      };
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_test_strap_pin = st_reg.pin_out;
  assign o_test_strap_oe = st_reg.pin_oe;
  assign o_test_strap_pulldown = st_reg.pull_en;

  // status; test mode is only reported, nothing here acts on it
  assign o_test_mode_sel = st_reg.mode_sel;
  assign o_test_mode = st_reg.test_mode;
  assign o_config_start = st_reg.start;
  assign o_ready = st_reg.ready;
  assign o_test_port_fault = st_reg.tport_fault;

endmodule // rtsc_top

`default_nettype wire

// File: sim/rtsc_chk_sva.sv
// port checker for the reset and strap block
`default_nettype none
module rtsc_chk
  import rtsc_pkg::*;
#(parameter int unsigned DELAY_CYC = 4) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_power_on_reset_low,
  input wire logic i_test_port_reset_low,
  input wire logic [STRAP_W-1:0] i_test_strap_pin,
  input wire logic [STRAP_W-1:0] i_test_out_data,
  input wire logic [STRAP_W-1:0] o_test_strap_pin,
  input wire logic [STRAP_W-1:0] o_test_strap_oe,
  input wire logic [STRAP_W-1:0] o_test_strap_pulldown,
  input wire logic [STRAP_W-1:0] o_test_mode_sel,
  input wire logic o_test_mode,
  input wire logic o_config_start,
  input wire logic o_ready,
  input wire logic o_test_port_fault
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // four samples low covers two sync stages plus the state update
  sequence s_low; !i_power_on_reset_low [*4]; endsequence
  property p_start; $rose(i_power_on_reset_low) |-> ##[3:4] o_config_start; endproperty
  a_start: assert property (p_start) else $error("no config start");
  property p_hold; s_low |-> o_test_strap_oe == 8'h00 && !o_ready && !o_config_start; endproperty
  a_hold: assert property (p_hold) else $error("active in reset");
  property p_time; $rose(o_ready) |-> $past(o_config_start, DELAY_CYC + 2); endproperty
  a_time: assert property (p_time) else $error("sample delay");
  property p_cap; $rose(o_ready) |-> o_test_mode_sel == $past(i_test_strap_pin, 3); endproperty
  a_cap: assert property (p_cap) else $error("strap capture");
  property p_mode; o_ready |-> o_test_mode == (|o_test_mode_sel); endproperty
  a_mode: assert property (p_mode) else $error("test mode");
  property p_drv; o_ready ##1 o_ready |-> o_test_strap_pin == $past(i_test_out_data); endproperty
  a_drv: assert property (p_drv) else $error("test output");
  property p_oe; o_test_strap_oe == {STRAP_W{o_ready}}; endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  property p_pull; o_test_strap_pulldown == 8'hff; endproperty
  a_pull: assert property (p_pull) else $error("pull-down");
  property p_fault; o_ready ##1 o_ready |-> o_test_port_fault == $past(i_test_port_reset_low, 3); endproperty
  a_fault: assert property (p_fault) else $error("test port fault");
  property p_nofault; !o_ready |-> !o_test_port_fault; endproperty
  a_nofault: assert property (p_nofault) else $error("fault while idle");
endmodule // rtsc_chk
bind rtsc_top rtsc_chk #(.DELAY_CYC(DELAY_CYC)) u_chk (.*);
`default_nettype wire

// File: sim/rtsc_pmic.sv
// power manager model driving the reset pins
`default_nettype none
module rtsc_pmic (
  input wire logic i_ref_clk,
  output var logic o_power_on_reset_low,
  output var logic o_test_port_reset_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_test_port_reset_low = 1'b0;
  initial o_power_on_reset_low = 1'b0;
  // only a fault scenario lifts the test port reset
  task automatic set_tport(input logic v);
    @(negedge i_ref_clk);
    o_test_port_reset_low = v;
  endtask
  // supplies get n cycles to settle before a release
  task automatic drive(input logic v, input int n);
    repeat (n) @(negedge i_ref_clk);
    o_power_on_reset_low = v;
  endtask
endmodule // rtsc_pmic
`default_nettype wire

// File: sim/reset_and_test_strap_control_tb.sv
// self-checking bench for the reset and strap block
`default_nettype none
module reset_and_test_strap_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtsc_pkg::*;
  localparam int unsigned D = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [STRAP_W-1:0] ext = 8'h00;
  logic [STRAP_W-1:0] tdat = 8'h00;
  wire logic por_n;
  wire logic tp_n;
  wire logic cfg;
  wire logic rdy;
  wire logic tmode;
  wire logic tflt;
  wire logic [STRAP_W-1:0] pout;
  wire logic [STRAP_W-1:0] oe;
  wire logic [STRAP_W-1:0] sel;
  wire logic [STRAP_W-1:0] pins;
  int n_mismatch = 0;
  int tests_run = 0;
  // undriven pins sit at the pull-down unless pulled up outside
  assign pins = (oe & pout) | (~oe & ext);
  initial forever #4 clk = ~clk;
  rtsc_pmic pm (.i_ref_clk(clk), .o_power_on_reset_low(por_n), .o_test_port_reset_low(tp_n));
  rtsc_top #(.DELAY_CYC(D)) dut (.i_ref_clk(clk), .i_rst(rst), .i_power_on_reset_low(por_n),
    .i_test_port_reset_low(tp_n), .i_test_strap_pin(pins), .o_test_strap_pin(pout),
    .o_test_strap_oe(oe), .o_test_strap_pulldown(), .i_test_out_data(tdat), .o_test_mode_sel(sel),
    .o_test_mode(tmode), .o_config_start(cfg), .o_ready(rdy), .o_test_port_fault(tflt));
  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (!ok)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic up();
    int n;
    int starts;
    starts = 0;
    pm.drive(1'b1, 3);
    for (n = 0; n < D + 12 && rdy !== 1'b1; n++)
    begin
      @(negedge clk);
      if (cfg === 1'b1)
        starts++;
    end
    chk(n >= D + 5 && n <= D + 6, "ready delay");
    chk(starts == 1, "config start");
    if (rdy !== 1'b1)
      end_of_test();
  endtask
  task automatic down();
    pm.drive(1'b0, 1);
    repeat (4) @(negedge clk);
    chk(oe === 8'h00 && rdy === 1'b0 && cfg === 1'b0 && tflt === 1'b0, "active in reset");
  endtask
  task automatic t_strap(input logic [STRAP_W-1:0] v);
    down();
    ext = v;
    up();
    ext = 8'h00;
    chk(sel === v && tmode === (v != 8'h00), "strap capture");
    tdat = ~v;
    repeat (2) @(negedge clk);
    chk(pout === ~v && oe === 8'hff, "test output");
  endtask
  // drop reset in mid-wait: no capture, then a full restart
  task automatic t_abort();
    down();
    pm.drive(1'b1, 1);
    repeat (2) @(negedge clk);
    down();
    chk(sel === 8'h40, "capture held");
    up();
  endtask
  // test port reset lifted while running raises the fault flag
  task automatic t_fault();
    chk(tflt === 1'b0, "fault idle");
    pm.set_tport(1'b1);
    repeat (4) @(negedge clk);
    chk(tflt === 1'b1 && rdy === 1'b1, "fault flag");
    pm.set_tport(1'b0);
    repeat (4) @(negedge clk);
    chk(tflt === 1'b0, "fault clear");
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_strap(8'h00);
    t_strap(8'h81);
    t_strap(8'h40);
    t_abort();
    t_fault();
    end_of_test();
  end
endmodule // reset_and_test_strap_control_tb
`default_nettype wire
